/* File: lpt_timing.sv */
// LCD panel timing configuration: APB registers, counters and derived pulses
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module lpt_timing
   import lpt_pkg::*;
#(
   parameter int PIX_W  = 11,
   parameter int LINE_W = 10
) (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        hsync_in,
   input  wire logic        int_vsync_in,
   input  wire logic        ext_vsync_in,
   output logic             horiz_start_pulse,
   output logic             vert_start_pulse,
   output logic             horiz_sync_out,
   output logic             vert_sync_out,
   output logic             black_frame_out,
   output logic             clamp_pulse,
   output logic             clamp_ext_mode,
   output logic      [5:0]  sh_phase,
   output logic             sh_bypass,
   output logic             line_decimate
);
   // Live register fields
   logic             horiz_out_polarity, vert_out_polarity, ext_vsync_select, overscan_black_frame_en;
   logic [1:0]       clamp_sel_ff, tv_sel_ff;
   logic [2:0]       sh_sel_ff, side_blank_offset;
   logic [5:0]       hpos_ff;
   logic [4:0]       vpos_ff, hdpos_ff;
   // Frame-aligned copies
   logic             a_ovs_ff;
   logic [1:0]       a_clamp_ff, a_tv_ff;
   logic [2:0]       a_sh_ff, a_sb_ff;
   logic [5:0]       a_hpos_ff;
   logic [4:0]       a_vpos_ff, a_hdpos_ff;
   // Counters and strobes
   logic [PIX_W-1:0]  pix_cnt_ff;
   logic [LINE_W-1:0] line_cnt_ff;
   logic [3:0]        dec_cnt_ff, dec_per;
   logic [1:0]        div_ff;
   logic              pix_en, hs_edge, vs_edge, vs_level, wr_en, rd_en, addr_ok;
   logic [31:0]       prdata_ff, rd_mux;
   lpt_tv_t           tv_mode;

   // True when val lies in [lo, lo+width)
   function automatic logic in_win(input logic [10:0] val, input logic [10:0] lo, input logic [10:0] width);
      in_win = (val >= lo) && (val < 11'(lo + width));
   endfunction : in_win

   // APB: zero-wait slave, error on unmapped offsets
   assign addr_ok = (paddr inside {ADDR_CTRL, ADDR_MODE, ADDR_HPOS, ADDR_VPOS, ADDR_SBPOS, ADDR_HDPOS, ADDR_STATUS});
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_en   = psel & penable & pwrite & addr_ok;
   assign rd_en   = psel & ~penable & ~pwrite;
   assign prdata  = prdata_ff;

   // Register writes
   always_ff @(posedge clock) begin
      if (srst) begin
         horiz_out_polarity      <= CTRL_RST[CTRL_HPOL_BIT];
         vert_out_polarity       <= CTRL_RST[CTRL_VPOL_BIT];
         ext_vsync_select        <= CTRL_RST[CTRL_EXTV_BIT];
         overscan_black_frame_en <= CTRL_RST[CTRL_OVS_BIT];
         clamp_sel_ff            <= MODE_RST[MODE_CLAMP_LSB +: 2];
         tv_sel_ff               <= MODE_RST[MODE_TV_LSB +: 2];
         sh_sel_ff               <= MODE_RST[MODE_SH_LSB +: 3];
         hpos_ff                 <= HPOS_RST;
         vpos_ff                 <= VPOS_RST;
         side_blank_offset       <= SBPOS_RST;
         hdpos_ff                <= HDPOS_RST;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_CTRL: begin
               horiz_out_polarity      <= pwdata[CTRL_HPOL_BIT];
               vert_out_polarity       <= pwdata[CTRL_VPOL_BIT];
               ext_vsync_select        <= pwdata[CTRL_EXTV_BIT];
               overscan_black_frame_en <= pwdata[CTRL_OVS_BIT];
            end
            ADDR_MODE: begin
               clamp_sel_ff <= pwdata[MODE_CLAMP_LSB +: 2];
               tv_sel_ff    <= pwdata[MODE_TV_LSB +: 2];
               sh_sel_ff    <= pwdata[MODE_SH_LSB +: 3];
            end
            ADDR_HPOS:  hpos_ff           <= pwdata[5:0];
            ADDR_VPOS:  vpos_ff           <= pwdata[4:0];
            ADDR_SBPOS: side_blank_offset <= pwdata[2:0];
            ADDR_HDPOS: hdpos_ff          <= pwdata[4:0];
            default: begin
            end
         endcase
      end
   end

   // Read mux, captured in the setup phase
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         ADDR_CTRL: begin
            rd_mux[CTRL_HPOL_BIT] = horiz_out_polarity;
            rd_mux[CTRL_VPOL_BIT] = vert_out_polarity;
            rd_mux[CTRL_EXTV_BIT] = ext_vsync_select;
            rd_mux[CTRL_OVS_BIT]  = overscan_black_frame_en;
         end
         ADDR_MODE: begin
            rd_mux[MODE_CLAMP_LSB +: 2] = clamp_sel_ff;
            rd_mux[MODE_TV_LSB +: 2]    = tv_sel_ff;
            rd_mux[MODE_SH_LSB +: 3]    = sh_sel_ff;
         end
         ADDR_HPOS:   rd_mux[5:0] = hpos_ff;
         ADDR_VPOS:   rd_mux[4:0] = vpos_ff;
         ADDR_SBPOS:  rd_mux[2:0] = side_blank_offset;
         ADDR_HDPOS:  rd_mux[4:0] = hdpos_ff;
         ADDR_STATUS: begin
            rd_mux[STAT_LINE_LSB +: LINE_W] = line_cnt_ff;
            rd_mux[STAT_EXTV_BIT]           = ext_vsync_select;
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (rd_en) begin
         prdata_ff <= rd_mux;
      end
   end

   // Vertical source select is live so the source can change with no frame
   assign vs_level = ext_vsync_select ? ext_vsync_in : int_vsync_in;

   lpt_edge u_hs_edge (
      .clock      (clock),
      .srst       (srst),
      .level      (hsync_in),
      .neg_pol    (1'b0),
      .edge_pulse (hs_edge)
   );

   lpt_edge u_vs_edge (
      .clock      (clock),
      .srst       (srst),
      .level      (vs_level),
      .neg_pol    (1'b0),
      .edge_pulse (vs_edge)
   );

   // Pixel step enable; divider restarts at each line so the first pixel step of a line has full length
   always_ff @(posedge clock) begin
      if (srst || hs_edge || div_ff == 2'(PIX_DIV - 1)) begin
         div_ff <= 2'h0;
      end else begin
         div_ff <= div_ff + 2'h1;
      end
   end
   assign pix_en = (div_ff == 2'(PIX_DIV - 1));

   // Copy mode and position fields at each field start
   always_ff @(posedge clock) begin
      if (srst) begin
         a_ovs_ff   <= CTRL_RST[CTRL_OVS_BIT];
         a_clamp_ff <= MODE_RST[MODE_CLAMP_LSB +: 2];
         a_tv_ff    <= MODE_RST[MODE_TV_LSB +: 2];
         a_sh_ff    <= MODE_RST[MODE_SH_LSB +: 3];
         a_hpos_ff  <= HPOS_RST;
         a_vpos_ff  <= VPOS_RST;
         a_sb_ff    <= SBPOS_RST;
         a_hdpos_ff <= HDPOS_RST;
      end else if (vs_edge) begin
         a_ovs_ff   <= overscan_black_frame_en;
         a_clamp_ff <= clamp_sel_ff;
         a_tv_ff    <= tv_sel_ff;
         a_sh_ff    <= sh_sel_ff;
         a_hpos_ff  <= hpos_ff;
         a_vpos_ff  <= vpos_ff;
         a_sb_ff    <= side_blank_offset;
         a_hdpos_ff <= hdpos_ff;
      end
   end

   // Pixel and line counters restarted by input sync edges
   always_ff @(posedge clock) begin
      if (srst || hs_edge) begin
         pix_cnt_ff <= '0;
      end else if (pix_en && pix_cnt_ff != '1) begin
         pix_cnt_ff <= pix_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst || vs_edge) begin
         line_cnt_ff <= '0;
      end else if (hs_edge && line_cnt_ff != '1) begin
         line_cnt_ff <= line_cnt_ff + 1'b1;
      end
   end

   // PAL line decimation cycle counter
   assign tv_mode = tv_decode(a_tv_ff);
   assign dec_per = (tv_mode == TV_PAL14) ? DEC_PER_14 : DEC_PER_12;
   always_ff @(posedge clock) begin
      if (srst || vs_edge) begin
         dec_cnt_ff <= 4'h0;
      end else if (hs_edge) begin
         dec_cnt_ff <= (dec_cnt_ff >= dec_per - 4'h1) ? 4'h0 : dec_cnt_ff + 4'h1;
      end
   end

   // Start pulses
   always_ff @(posedge clock) begin
      if (srst) begin
         horiz_start_pulse <= 1'b0;
         vert_start_pulse  <= 1'b0;
      end else begin
         horiz_start_pulse <= pix_en && (pix_cnt_ff == PIX_W'(a_hpos_ff));
         vert_start_pulse  <= hs_edge && (line_cnt_ff == LINE_W'(a_vpos_ff));
      end
   end

   // Sync outputs with selectable polarity
   always_ff @(posedge clock) begin
      if (srst) begin
         horiz_sync_out <= 1'b0;
         vert_sync_out  <= 1'b0;
      end else begin
         horiz_sync_out <= in_win(pix_cnt_ff, {4'h0, a_hdpos_ff, 2'b00}, HD_WIDTH) ^ horiz_out_polarity;
         vert_sync_out  <= (line_cnt_ff < VD_LINES) ^ vert_out_polarity;
      end
   end

   // Overscan black frame at sides and top/bottom
   always_ff @(posedge clock) begin
      if (srst) begin
         black_frame_out <= 1'b0;
      end else begin
         black_frame_out <= a_ovs_ff && (
            (pix_cnt_ff < 11'(SB_BASE + 11'(a_sb_ff))) ||
            (pix_cnt_ff >= 11'(H_ACTIVE - SB_BASE - 11'(a_sb_ff))) ||
            (line_cnt_ff < TB_LINES) || (line_cnt_ff >= V_ACTIVE - TB_LINES));
      end
   end

   // Clamp, sample-hold and decimation outputs
   always_ff @(posedge clock) begin
      if (srst) begin
         clamp_pulse    <= 1'b0;
         clamp_ext_mode <= 1'b0;
         sh_phase       <= 6'h00;
         sh_bypass      <= 1'b0;
         line_decimate  <= 1'b0;
      end else begin
         clamp_pulse    <= in_win(pix_cnt_ff, a_clamp_ff[0] ? 11'h000 : CLAMP_PED, CLAMP_W);
         clamp_ext_mode <= a_clamp_ff[1];
         sh_phase       <= (a_sh_ff < SH_THRU_MIN) ? 6'(6'h01 << a_sh_ff) : 6'h00;
         sh_bypass      <= (a_sh_ff >= SH_THRU_MIN);
         line_decimate  <= (tv_mode != TV_NTSC) &&
                           (dec_cnt_ff == DEC_FIRST || dec_cnt_ff == dec_per - 4'h1);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   ext_src_a:     assert property (ext_vsync_select |-> vs_level == ext_vsync_in)
                     else $error("vertical source not external");
   black_off_a:   assert property (!a_ovs_ff |=> !black_frame_out)
                     else $error("black frame without overscan");
   clamp_sync_a:  assert property ((a_clamp_ff[0] && pix_cnt_ff < CLAMP_W) |=> clamp_pulse)
                     else $error("sync clamp missing");
   ntsc_nodec_a:  assert property ((tv_mode == TV_NTSC) |=> !line_decimate)
                     else $error("decimation in NTSC");
   hstart_pos_a:  assert property ((pix_en && pix_cnt_ff == PIX_W'(a_hpos_ff)) |=> horiz_start_pulse)
                     else $error("horizontal start misplaced");
   sh_thru_a:     assert property ((a_sh_ff >= SH_THRU_MIN) |=> (sh_bypass && sh_phase == 6'h00))
                     else $error("sample-hold not bypassed");
   vstart_pos_a:  assert property ((hs_edge && line_cnt_ff == LINE_W'(a_vpos_ff)) |=> vert_start_pulse)
                     else $error("vertical start misplaced");
   sb_left_a:     assert property ((a_ovs_ff && pix_cnt_ff < 11'(SB_BASE + 11'(a_sb_ff))) |=> black_frame_out)
                     else $error("side blank missing");
   hd_pos_a:      assert property ((pix_cnt_ff == {4'h0, a_hdpos_ff, 2'b00} && horiz_out_polarity)
                     |=> !horiz_sync_out)
                     else $error("horizontal sync out misplaced");
   vpol_a:        assert property ((line_cnt_ff < VD_LINES && !vert_out_polarity) |=> vert_sync_out)
                     else $error("vertical sync out polarity");
   cnt_restart_a: assert property (hs_edge |=> pix_cnt_ff == '0)
                     else $error("pixel counter not restarted");
   shadow_a:      assert property (!vs_edge |=> $stable(a_hpos_ff) && $stable(a_tv_ff))
                     else $error("mode changed inside field");

   ovs_cov_c:  cover property (a_ovs_ff && black_frame_out);
   pal_cov_c:  cover property (tv_mode == TV_PAL14 && line_decimate);
   extv_cov_c: cover property (ext_vsync_select && vert_start_pulse);
endmodule : lpt_timing

/* File: lpt_pkg.sv */
// Constants and types shared by the panel timing configuration block
package lpt_pkg;

   // APB register offsets (byte addresses)
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_MODE   = 8'h04;
   localparam logic [7:0] ADDR_HPOS   = 8'h08;
   localparam logic [7:0] ADDR_VPOS   = 8'h0C;
   localparam logic [7:0] ADDR_SBPOS  = 8'h10;
   localparam logic [7:0] ADDR_HDPOS  = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // CTRL field positions
   localparam int CTRL_HPOL_BIT = 0;
   localparam int CTRL_VPOL_BIT = 1;
   localparam int CTRL_EXTV_BIT = 6;
   localparam int CTRL_OVS_BIT  = 7;

   // MODE field positions
   localparam int MODE_CLAMP_LSB = 0;
   localparam int MODE_TV_LSB    = 2;
   localparam int MODE_SH_LSB    = 6;

   // STATUS field positions
   localparam int STAT_LINE_LSB  = 0;
   localparam int STAT_EXTV_BIT  = 16;

   // Reset values
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] MODE_RST  = 32'h0000_0000;
   localparam logic [5:0]  HPOS_RST  = 6'h00;
   localparam logic [4:0]  VPOS_RST  = 5'h00;
   localparam logic [2:0]  SBPOS_RST = 3'h0;
   localparam logic [4:0]  HDPOS_RST = 5'h00;

   // Timing counts (pixel and line units)
   localparam int          PIX_DIV      = 2;        // System clocks per pixel step
   localparam logic [10:0] HD_WIDTH     = 11'h010;  // Horizontal sync out width, pixels
   localparam logic [10:0] CLAMP_PED    = 11'h018;  // Pedestal clamp start, pixels
   localparam logic [10:0] CLAMP_W      = 11'h008;  // Clamp pulse width, pixels
   localparam logic [10:0] SB_BASE      = 11'h008;  // Side blank base width, pixels
   localparam logic [10:0] H_ACTIVE     = 11'h280;  // Line length used for right blank
   localparam logic [9:0]  VD_LINES     = 10'h003;  // Vertical sync out width, lines
   localparam logic [9:0]  TB_LINES     = 10'h010;  // Top and bottom blank, lines
   localparam logic [9:0]  V_ACTIVE     = 10'h0F0;  // Field length used for bottom blank
   localparam logic [3:0]  DEC_FIRST    = 4'h5;     // First dropped line of the cycle
   localparam logic [3:0]  DEC_PER_12   = 4'hC;     // 2 of 12 cycle
   localparam logic [3:0]  DEC_PER_14   = 4'hE;     // 2 of 14 cycle
   localparam logic [2:0]  SH_THRU_MIN  = 3'h6;     // Codes from here bypass sample-hold

   // Display systems
   typedef enum {TV_NTSC, TV_PAL12, TV_PAL14} lpt_tv_t;

   // Decode the two-bit display system field
   function automatic lpt_tv_t tv_decode(input logic [1:0] sel);
      unique case (sel)
         2'b01:   tv_decode = TV_PAL12;
         2'b11:   tv_decode = TV_PAL14;
         default: tv_decode = TV_NTSC;
      endcase
   endfunction : tv_decode

endpackage : lpt_pkg

/* File: lpt_edge.sv */
// Polarity-aware rising edge detector for incoming sync levels
`timescale 1ns/100ps
module lpt_edge (
   input  wire logic clock,
   input  wire logic srst,
   input  wire logic level,
   input  wire logic neg_pol,
   output logic      edge_pulse
);
   logic prev_ff;

   // Remember the previous asserted state
   always_ff @(posedge clock) begin
      if (srst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= level ^ neg_pol;
      end
   end

   // Pulse on the first cycle of an asserted sync
   assign edge_pulse = (level ^ neg_pol) & ~prev_ff;
endmodule : lpt_edge

/* File: lpt_host.sv */
// Host model: APB master that loads setting words into the timing block
`timescale 1ns/100ps
module lpt_host
   import lpt_pkg::*;
(
   input  wire logic        clock,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [7:0]  paddr,
   output logic      [31:0] pwdata
);
   // Bus idle at time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end

   // Setup cycle, then access held until pready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= addr;
      pwdata  <= wdata;
      @(posedge clock);
      penable <= 1'b1;
      do
         @(posedge clock);
      while (pready !== 1'b1);
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~wdata;  // Released bus does not keep its last value
   endtask : xfer

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] d;
      logic        e;
      xfer(1'b1, addr, data, d, e);
   endtask : wr

   task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic err);
      xfer(1'b0, addr, 32'h0000_0000, data, err);
   endtask : rd

   // Control word; composite sync on the horizontal input keeps the external vertical select off
   task automatic wr_ctrl(input logic [31:0] data, input logic composite);
      logic [31:0] v;
      v = data;
      if (composite)
         v[CTRL_EXTV_BIT] = 1'b0;
      wr(ADDR_CTRL, v);
   endtask : wr_ctrl
endmodule : lpt_host

/* File: testbench.sv */
// Self-checking testbench for the panel timing configuration block
`timescale 1ns/100ps
module testbench
   import lpt_pkg::*;
;
   logic        clock, srst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        hsync_in, int_vsync_in, ext_vsync_in;
   logic        horiz_start_pulse, vert_start_pulse, horiz_sync_out, vert_sync_out;
   logic        black_frame_out, clamp_pulse, clamp_ext_mode, sh_bypass, line_decimate;
   logic [5:0]  sh_phase;
   int          hc = 0;
   int          lc = 0;
   int          cyc = 0;
   int          n_fail = 0;
   int          check_count = 0;

   lpt_timing uut (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .hsync_in(hsync_in), .int_vsync_in(int_vsync_in), .ext_vsync_in(ext_vsync_in),
      .horiz_start_pulse(horiz_start_pulse), .vert_start_pulse(vert_start_pulse),
      .horiz_sync_out(horiz_sync_out), .vert_sync_out(vert_sync_out), .black_frame_out(black_frame_out),
      .clamp_pulse(clamp_pulse), .clamp_ext_mode(clamp_ext_mode), .sh_phase(sh_phase),
      .sh_bypass(sh_bypass), .line_decimate(line_decimate));
   lpt_host host (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   always #5 clock = ~clock;

   // Sync source: 100 clocks a line, 20 lines a field, vsync mid-line 0 (internal) and 7 (external)
   always @(posedge clock) begin
      hc <= (hc == 99) ? 0 : hc + 1;
      if (hc == 99)
         lc <= (lc == 19) ? 0 : lc + 1;
      hsync_in     <= (hc == 99) || (hc < 7);
      int_vsync_in <= (lc == 0) && (hc >= 49) && (hc < 89);
      ext_vsync_in <= (lc == 7) && (hc >= 49) && (hc < 89);
   end

   // Cut a hung run short
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         n_fail++;
         results();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wait_pos(input int l, input int k);
      do begin
         @(posedge clock);
         #1;
      end while (!(lc == l && hc == k));
   endtask : wait_pos

   // Pass the next vertical sync so frame-aligned settings are in force
   task automatic next_field;
      if (lc == 0 && hc >= 40)
         wait_pos(1, 0);
      wait_pos(0, 95);
   endtask : next_field

   task automatic first_hc(input int l, input logic sync_sel, output int pos);
      pos = -1;
      wait_pos(l, 0);
      while (lc == l) begin
         if (pos < 0 && (sync_sel ? horiz_sync_out : horiz_start_pulse) === 1'b1)
            pos = hc;
         @(posedge clock);
         #1;
      end
   endtask : first_hc

   task automatic t_regs;
      logic [7:0]  a [6] = '{ADDR_CTRL, ADDR_MODE, ADDR_HPOS, ADDR_VPOS, ADDR_SBPOS, ADDR_HDPOS};
      logic [31:0] m [6] = '{32'h0000_00C3, 32'h0000_01CF, 32'h0000_003F, 32'h0000_001F, 32'h0000_0007,
                             32'h0000_001F};
      logic [31:0] d;
      logic        e;
      for (int i = 0; i < 6; i++) begin
         host.rd(a[i], d, e);
         chk("reset value", 32'h0000_0000, d);
         host.wr(a[i], 32'hFFFF_FFFF);
         host.rd(a[i], d, e);
         chk("readback", m[i], d);
         chk("mapped err", 32'h0000_0000, 32'(e));
         host.wr(a[i], 32'h0000_0000);
      end
      host.wr(ADDR_STATUS, 32'hFFFF_FFFF);
      host.rd(ADDR_STATUS, d, e);
      chk("status ro", 32'h0000_0000, d & 32'h0001_0000);
      host.wr(8'h1C, 32'hFFFF_FFFF);
      host.rd(8'h1C, d, e);
      chk("unmapped data", 32'h0000_0000, d);
      chk("unmapped err", 32'h0000_0001, 32'(e));
   endtask : t_regs

   task automatic t_source;
      logic [31:0] d;
      logic        e;
      host.wr_ctrl(32'h0000_0040, 1'b0);
      wait_pos(8, 0);
      wait_pos(5, 60);
      host.rd(ADDR_STATUS, d, e);
      chk("line ext", 32'h0001_0012, d & 32'h0001_03FF);
      host.wr_ctrl(32'h0000_0043, 1'b1);
      wait_pos(1, 50);
      chk("vsync inv", 32'h0000_0000, 32'(vert_sync_out));
      wait_pos(5, 15);
      chk("hsync inv", 32'h0000_0000, 32'(horiz_sync_out));
      chk("vsync inv idle", 32'h0000_0001, 32'(vert_sync_out));
      host.rd(ADDR_STATUS, d, e);
      chk("line int", 32'h0000_0005, d & 32'h0001_03FF);
      host.wr_ctrl(32'h0000_0000, 1'b1);
      wait_pos(1, 50);
      chk("vsync pos", 32'h0000_0001, 32'(vert_sync_out));
      wait_pos(2, 15);
      chk("hsync pos", 32'h0000_0001, 32'(horiz_sync_out));
   endtask : t_source

   task automatic t_hpos;
      int p0, p1, pm, q0, q1;
      host.wr(ADDR_HPOS, 32'd3);
      next_field();
      first_hc(3, 1'b0, p0);
      first_hc(4, 1'b1, q0);
      host.wr(ADDR_HPOS, 32'd13);
      host.wr(ADDR_HDPOS, 32'd5);
      first_hc(7, 1'b0, pm);
      next_field();
      first_hc(3, 1'b0, p1);
      first_hc(4, 1'b1, q1);
      chk("start held", 32'(p0), 32'(pm));
      chk("start offset", 32'd20, 32'(p1 - p0));
      chk("hsync offset", 32'd40, 32'(q1 - q0));
   endtask : t_hpos

   task automatic t_vpos;
      int l [2];
      for (int i = 0; i < 2; i++) begin
         host.wr(ADDR_VPOS, (i == 0) ? 32'd2 : 32'd9);
         next_field();
         l[i] = -1;
         wait_pos(1, 0);
         repeat (1890) begin
            if (l[i] < 0 && vert_start_pulse === 1'b1)
               l[i] = lc;
            @(posedge clock);
            #1;
         end
      end
      chk("vstart offset", 32'd7, 32'(l[1] - l[0]));
   endtask : t_vpos

   task automatic t_frame;
      wait_pos(5, 50);
      chk("black off", 32'h0000_0000, 32'(black_frame_out));
      host.wr(ADDR_SBPOS, 32'd2);
      host.wr_ctrl(32'h0000_0080, 1'b1);
      next_field();
      wait_pos(5, 50);
      chk("black top", 32'h0000_0001, 32'(black_frame_out));
      wait_pos(17, 24);
      chk("black side 2", 32'h0000_0000, 32'(black_frame_out));
      host.wr(ADDR_SBPOS, 32'd7);
      next_field();
      wait_pos(17, 24);
      chk("black side 7", 32'h0000_0001, 32'(black_frame_out));
      host.wr_ctrl(32'h0000_0000, 1'b1);
   endtask : t_frame

   task automatic t_modes;
      logic [1:0] c;
      int         n, f0, f1;
      for (int i = 0; i < 8; i++) begin
         c = 2'(i);
         host.wr(ADDR_MODE, 32'(i << 6) | {28'h0, c, c});
         wait_pos(lc, 70);
         chk("bypass held", 32'(i == 7), 32'(sh_bypass));
         next_field();
         wait_pos(3, 8);
         chk("sh phase", (i < 6) ? 32'(1 << i) : 32'h0, 32'(sh_phase));
         chk("sh bypass", 32'(i >= 6), 32'(sh_bypass));
         chk("clamp ext", 32'(c[1]), 32'(clamp_ext_mode));
         chk("clamp sync", 32'(c[0]), 32'(clamp_pulse));
         wait_pos(3, 56);
         chk("clamp pedestal", 32'(!c[0]), 32'(clamp_pulse));
         n = 0;
         f0 = 0;
         f1 = 0;
         wait_pos(4, 50);
         while (lc != 0) begin
            n = n + int'(line_decimate === 1'b1);
            if (line_decimate === 1'b1 && n == 1)
               f0 = lc;
            if (line_decimate === 1'b1 && n == 2)
               f1 = lc;
            wait_pos((lc + 1) % 20, 50);
         end
         chk("drop gap", (c == 2'b01) ? 32'd6 : (c == 2'b11) ? 32'd8 : 32'd0, 32'(f1 - f0));
      end
   endtask : t_modes

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   // Time-zero values, reset, then the scenarios
   initial begin
      clock = 1'b0;
      srst = 1'b1;
      hsync_in = 1'b0;
      int_vsync_in = 1'b0;
      ext_vsync_in = 1'b0;
      repeat (16) @(posedge clock);
      srst <= 1'b0;
      t_regs();
      t_source();
      t_hpos();
      t_vpos();
      t_frame();
      t_modes();
      results();
   end
endmodule : testbench
